/* File: rtl/diag_state_ctrl.sv */
`timescale 1ns/10ps
module diag_state_ctrl
   import selftest_launch_pkg::*;
#(
   parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst_n,
   input  wire logic          i_ce,
   input  wire logic          i_dev_reset,
   input  wire logic          i_leave_request,
   input  wire logic          i_leave_block,
   input  wire logic          i_timeout_flag_rd,
   output device_state_t      o_state,
   output logic               o_timeout_flag,
   output logic [3:0]         o_fault_count
);

   logic [31:0] timer_reg;
   logic        timeout;

   // timer keeps running through a logic self-test run
   assign timeout = (o_state == ST_DIAG) && (timer_reg == 32'(TIMEOUT_CYC - 1));

   // ****************************************
   // state and timer
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_state   <= ST_DIAG;
         timer_reg <= 32'h0000_0000;
      end else if (i_ce) begin
         if (i_dev_reset) begin
            o_state   <= ST_DIAG;
            timer_reg <= 32'h0000_0000;
         end else begin
            case (o_state)
               ST_DIAG: begin
                  timer_reg <= timer_reg + 32'h0000_0001;
                  if (timeout) begin
                     o_state <= ST_SAFE;
                  end else if (i_leave_request && !i_leave_block) begin
                     o_state <= ST_ACTIVE;
                  end
               end
               ST_ACTIVE: timer_reg <= 32'h0000_0000;
               ST_SAFE:   timer_reg <= 32'h0000_0000;
               default:   o_state   <= ST_DIAG;
            endcase
         end
      end
   end

   // ****************************************
   // timeout flag and fault counter
   // ****************************************
   // set wins over a read-clear in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_timeout_flag <= 1'b0;
      end else if (i_ce) begin
         o_timeout_flag <= (o_timeout_flag && !i_timeout_flag_rd) || timeout;
      end
   end

   // saturates rather than wrapping back to zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fault_count <= 4'h0;
      end else if (i_ce && timeout && !i_dev_reset && o_fault_count != FAULT_CNT_MAX) begin
         o_fault_count <= o_fault_count + 4'h1;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_timeout_to_safe: assert property (i_ce && timeout && !i_dev_reset |=>
      o_state == ST_SAFE && o_timeout_flag)
      else $error("timeout did not reach safe state");
   a_exit_needs_unmask: assert property ($past(i_ce) && $past(o_state) == ST_DIAG
      && o_state == ST_ACTIVE |-> $past(i_leave_request) && !$past(i_leave_block))
      else $error("left diagnostic state without request or while blocked");
   a_count_step: assert property (i_ce && timeout && !i_dev_reset
      && o_fault_count != FAULT_CNT_MAX |=> o_fault_count == $past(o_fault_count) + 4'h1)
      else $error("fault counter did not step by one");
   c_timeout: cover property (o_state == ST_DIAG ##1 o_state == ST_SAFE);

endmodule : diag_state_ctrl

/* File: rtl/safety_selftest_launch_control.sv */
`timescale 1ns/10ps
module safety_selftest_launch_control
   import selftest_launch_pkg::*;
#(
   parameter int TIMEOUT_CYC = DIAG_TIMEOUT_CYC
) (
   input  wire logic           i_clk,
   input  wire logic           i_rst_n,
   input  wire logic           i_ce,
   input  wire logic           i_dev_reset,
   input  wire logic           i_selftest_ctrl_write_lock,
   input  wire reg_write_t     i_reg_write,
   input  wire analog_report_t i_analog_report,
   input  wire logic_report_t  i_logic_report,
   input  wire logic           i_analog_sched_en,
   input  wire logic           i_analog_flags_rd,
   input  wire logic           i_logic_result_rd,
   input  wire logic           i_nvm_crc_err,
   input  wire logic           i_nvm_fault_clr,
   input  wire logic           i_leave_block_wr,
   input  wire logic           i_leave_block_data,
   input  wire logic           i_diag_leave_request,
   input  wire logic           i_timeout_flag_rd,
   input  wire logic           i_enable_pin_drive,
   output logic [7:0]          o_analog_selftest_launch,
   output logic [7:0]          o_logic_selftest_diag_launch,
   output logic [3:0]          o_analog_group_done_flag,
   output logic [3:0]          o_analog_group_fail_flag,
   output logic [6:0]          o_logic_selftest_result,
   output logic                o_nvm_crc_fault_flag,
   output logic                o_diag_leave_block,
   output logic                o_enable_or_interrupt_pin,
   output device_state_t       o_state,
   output logic                o_diag_timeout_flag,
   output logic [3:0]          o_device_fault_counter
);

   // ****************************************
   // helpers
   // ****************************************
   // result bits owned by each launch bit of the logic register
   function automatic logic [6:0] result_mask(input int idx);
      logic [6:0] m;
      m = RESULT_RESET;
      case (idx)
         LS_GO_BIT: begin
            m[RES_D0] = 1'b1;
            m[RES_D1] = 1'b1;
         end
         ENPIN_CHECK_BIT:   m[RES_D3] = 1'b1;
         RSTOUT_CHECK_BIT:  m[RES_D4] = 1'b1;
         NVM_CHECK_BIT:     m[RES_D5] = 1'b1;
         CFG_CRC_CHECK_BIT: m[RES_D6] = 1'b1;
         LS_CHECK_BIT: begin
            m[RES_D0] = 1'b1;
            m[RES_D2] = 1'b1;
         end
         default:           m = RESULT_RESET;
      endcase
      return m;
   endfunction : result_mask

   logic       wr_ok;
   logic       wr_analog;
   logic       wr_logic;
   logic [7:0] analog_next;
   logic [7:0] logic_next;
   logic [7:0] analog_clr;
   logic [7:0] logic_clr;
   logic [6:0] result_upd;
   logic       ls_start;
   logic       ls_done;
   logic       nvm_done_ok;
   logic       keep_analog;
   logic       freeze_reg;

   assign wr_ok     = i_reg_write.valid && !i_selftest_ctrl_write_lock;
   assign wr_analog = wr_ok && i_reg_write.sel == SEL_ANALOG_LAUNCH;
   assign wr_logic  = wr_ok && i_reg_write.sel == SEL_LOGIC_LAUNCH;

   // periodic scheduler in active state keeps group bits armed
   assign keep_analog = i_analog_sched_en && (o_state == ST_ACTIVE);
   assign analog_clr  = keep_analog ? 8'h00 : {4'h0, i_analog_report.done};
   assign logic_clr   = {2'b00, i_logic_report.done};

   // ****************************************
   // launch registers
   // ****************************************
   always_comb begin
      analog_next = o_analog_selftest_launch & ~analog_clr;
      logic_next  = o_logic_selftest_diag_launch & ~logic_clr;
      if (wr_analog) begin
         analog_next = i_reg_write.data & ANALOG_LAUNCH_MASK;
      end
      if (wr_logic) begin
         logic_next = i_reg_write.data & LOGIC_LAUNCH_MASK;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog_selftest_launch     <= ANALOG_LAUNCH_RESET;
         o_logic_selftest_diag_launch <= LOGIC_LAUNCH_RESET;
      end else if (i_ce) begin
         if (i_dev_reset) begin
            o_analog_selftest_launch     <= ANALOG_LAUNCH_RESET;
            o_logic_selftest_diag_launch <= LOGIC_LAUNCH_RESET;
         end else begin
            o_analog_selftest_launch     <= analog_next;
            o_logic_selftest_diag_launch <= logic_next;
         end
      end
   end

   // ****************************************
   // analog status flags
   // ****************************************
   // only completions of launched groups count; set wins over read-clear
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_analog_group_done_flag <= FLAGS4_RESET;
         o_analog_group_fail_flag <= FLAGS4_RESET;
      end else if (i_ce) begin
         o_analog_group_done_flag <= (i_analog_flags_rd ? FLAGS4_RESET : o_analog_group_done_flag)
            | (i_analog_report.done & o_analog_selftest_launch[3:0]);
         o_analog_group_fail_flag <= (i_analog_flags_rd ? FLAGS4_RESET : o_analog_group_fail_flag)
            | (i_analog_report.done & i_analog_report.fail & o_analog_selftest_launch[3:0]);
      end
   end

   // ****************************************
   // logic self-test results
   // ****************************************
   always_comb begin
      result_upd = RESULT_RESET;
      for (int i = 0; i < 6; i++) begin
         if (i_logic_report.done[i] && o_logic_selftest_diag_launch[i]) begin
            result_upd = result_upd | result_mask(i);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_logic_selftest_result <= RESULT_RESET;
      end else if (i_ce) begin
         o_logic_selftest_result <= ((i_logic_result_rd ? RESULT_RESET : o_logic_selftest_result)
            & ~result_upd) | (i_logic_report.result & result_upd);
      end
   end

   // ****************************************
   // nonvolatile CRC fault flag
   // ****************************************
   // clear honoured only when no check runs and the last one passed
   assign nvm_done_ok = !o_logic_selftest_diag_launch[NVM_CHECK_BIT]
                        && !o_logic_selftest_result[RES_D5];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_nvm_crc_fault_flag <= 1'b0;
      end else if (i_ce) begin
         o_nvm_crc_fault_flag <= (o_nvm_crc_fault_flag && !(i_nvm_fault_clr && nvm_done_ok))
            || o_logic_selftest_diag_launch[NVM_CHECK_BIT] || i_nvm_crc_err;
      end
   end

   // ****************************************
   // run start, leave-block bit and pin freeze
   // ****************************************
   assign ls_start = wr_logic && !i_dev_reset && i_reg_write.data[LS_GO_BIT]
                     && !o_logic_selftest_diag_launch[LS_GO_BIT];
   assign ls_done  = o_logic_selftest_diag_launch[LS_GO_BIT] && i_logic_report.done[LS_GO_BIT];

   // hardware clear beats a host write so a run start can never be masked
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_diag_leave_block <= 1'b0;
      end else if (i_ce) begin
         if (ls_start && o_state == ST_DIAG) begin
            o_diag_leave_block <= 1'b0;
         end else if (i_leave_block_wr) begin
            o_diag_leave_block <= i_leave_block_data;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         freeze_reg <= 1'b0;
      end else if (i_ce) begin
         if (ls_start && (o_state == ST_ACTIVE || o_state == ST_SAFE)) begin
            freeze_reg <= 1'b1;
         end else if (ls_done || i_dev_reset) begin
            freeze_reg <= 1'b0;
         end
      end
   end

   // pin level held from a start cycle in active or safe state, released in the completion cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_enable_or_interrupt_pin <= 1'b0;
      end else if (i_ce) begin
         if (!(freeze_reg && !ls_done) && !(ls_start && o_state != ST_DIAG)) begin
            o_enable_or_interrupt_pin <= i_enable_pin_drive;
         end
      end
   end

   // ****************************************
   // diagnostic state control
   // ****************************************
   diag_state_ctrl #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_diag (
      .i_clk             (i_clk),
      .i_rst_n           (i_rst_n),
      .i_ce              (i_ce),
      .i_dev_reset       (i_dev_reset),
      .i_leave_request   (i_diag_leave_request),
      .i_leave_block     (o_diag_leave_block),
      .i_timeout_flag_rd (i_timeout_flag_rd),
      .o_state           (o_state),
      .o_timeout_flag    (o_diag_timeout_flag),
      .o_fault_count     (o_device_fault_counter)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_locked_no_write: assert property (i_ce && i_selftest_ctrl_write_lock
      && i_reg_write.valid && !i_dev_reset
      && i_analog_report.done == 4'h0 && i_logic_report.done == 6'h00
      |=> $stable(o_analog_selftest_launch) && $stable(o_logic_selftest_diag_launch))
      else $error("launch register changed while locked");
   a_dev_reset_clear: assert property (i_ce && i_dev_reset |=>
      o_analog_selftest_launch == 8'h00 && o_logic_selftest_diag_launch == 8'h00)
      else $error("device reset left launch bits set");
   a_analog_write: assert property (i_ce && !i_dev_reset && wr_analog |=>
      o_analog_selftest_launch == ($past(i_reg_write.data) & ANALOG_LAUNCH_MASK))
      else $error("analog launch write not taken");
   a_reserved_zero: assert property (
      (o_analog_selftest_launch & ~ANALOG_LAUNCH_MASK) == 8'h00
      && (o_logic_selftest_diag_launch & ~LOGIC_LAUNCH_MASK) == 8'h00)
      else $error("reserved launch bit set");
   a_analog_selfclear: assert property (i_ce && !i_dev_reset && !wr_analog
      && !keep_analog && i_analog_report.done[0] |=> !o_analog_selftest_launch[0])
      else $error("analog group bit did not self-clear");
   a_analog_sched_keep: assert property (i_ce && !i_dev_reset && keep_analog
      && o_analog_selftest_launch[3] && !wr_analog |=> o_analog_selftest_launch[3])
      else $error("scheduled analog bit dropped");
   a_group_done_flag: assert property (i_ce && i_analog_report.done[2]
      && o_analog_selftest_launch[2] && i_analog_report.fail[2]
      |=> o_analog_group_done_flag[2] && o_analog_group_fail_flag[2])
      else $error("group flags not set on completion");
   a_logic_selfclear: assert property (i_ce && !i_dev_reset && !wr_logic
      && i_logic_report.done[CFG_CRC_CHECK_BIT]
      |=> !o_logic_selftest_diag_launch[CFG_CRC_CHECK_BIT])
      else $error("check bit did not self-clear");
   a_run_selfclear: assert property (i_ce && !i_dev_reset && !wr_logic && ls_done
      |=> !o_logic_selftest_diag_launch[LS_GO_BIT])
      else $error("run bit did not self-clear");
   a_d6_result: assert property (i_ce && !i_logic_result_rd
      && o_logic_selftest_diag_launch[CFG_CRC_CHECK_BIT]
      && i_logic_report.done[CFG_CRC_CHECK_BIT]
      |=> o_logic_selftest_result[RES_D6] == $past(i_logic_report.result[RES_D6]))
      else $error("D6 not loaded from check result");
   a_nvm_fault_run: assert property (i_ce
      && o_logic_selftest_diag_launch[NVM_CHECK_BIT] |=> o_nvm_crc_fault_flag)
      else $error("nvm fault flag not set during check");
   a_nvm_clear_held: assert property (i_ce && o_nvm_crc_fault_flag
      && o_logic_selftest_result[RES_D5] |=> o_nvm_crc_fault_flag)
      else $error("nvm fault flag cleared after failed check");
   a_block_cleared: assert property (i_ce && ls_start && o_state == ST_DIAG
      |=> !o_diag_leave_block)
      else $error("run start did not clear leave-block bit");
   a_pin_frozen: assert property (freeze_reg && !ls_done && $past(freeze_reg) && i_ce
      |=> $stable(o_enable_or_interrupt_pin))
      else $error("enable pin moved while frozen");
   a_pin_follows: assert property (i_ce && !freeze_reg && !ls_start
      |=> o_enable_or_interrupt_pin == $past(i_enable_pin_drive))
      else $error("enable pin did not follow drive");

   c_run_active: cover property (ls_start && o_state == ST_ACTIVE ##[1:50] ls_done);
   c_nvm_check: cover property (o_logic_selftest_diag_launch[NVM_CHECK_BIT]
      ##[1:50] !o_logic_selftest_diag_launch[NVM_CHECK_BIT]);
   c_analog_all: cover property (o_analog_group_done_flag == 4'hF);
   c_diag_leave_request: cover property (o_state == ST_DIAG ##1 o_state == ST_ACTIVE);

endmodule : safety_selftest_launch_control

/* File: rtl/selftest_launch_pkg.sv */
package selftest_launch_pkg;

   // ****************************************
   // register layout
   // ****************************************
   localparam logic [7:0] ANALOG_LAUNCH_RESET = 8'h00;
   localparam logic [7:0] LOGIC_LAUNCH_RESET  = 8'h00;
   localparam logic [7:0] ANALOG_LAUNCH_MASK  = 8'h0F;
   localparam logic [7:0] LOGIC_LAUNCH_MASK   = 8'h3F;
   localparam logic       SEL_ANALOG_LAUNCH   = 1'b0;
   localparam logic       SEL_LOGIC_LAUNCH    = 1'b1;

   localparam int LS_GO_BIT         = 0;
   localparam int ENPIN_CHECK_BIT   = 1;
   localparam int RSTOUT_CHECK_BIT  = 2;
   localparam int NVM_CHECK_BIT     = 3;
   localparam int CFG_CRC_CHECK_BIT = 4;
   localparam int LS_CHECK_BIT      = 5;

   // result bit positions D0..D6
   localparam int RES_D0 = 0;
   localparam int RES_D1 = 1;
   localparam int RES_D2 = 2;
   localparam int RES_D3 = 3;
   localparam int RES_D4 = 4;
   localparam int RES_D5 = 5;
   localparam int RES_D6 = 6;

   localparam logic [6:0] RESULT_RESET  = 7'h00;
   localparam logic [3:0] FLAGS4_RESET  = 4'h0;
   localparam logic [3:0] FAULT_CNT_MAX = 4'hF;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS   = 10;
   localparam int DIAG_TIMEOUT_MS = 256;
   localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      ST_DIAG   = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_SAFE   = 2'b10
   } device_state_t;

   typedef struct packed {
      logic       valid;
      logic       sel;
      logic [7:0] data;
   } reg_write_t;

   typedef struct packed {
      logic [3:0] done;
      logic [3:0] fail;
   } analog_report_t;

   typedef struct packed {
      logic [5:0] done;
      logic [6:0] result;
   } logic_report_t;

endpackage : selftest_launch_pkg

/* File: verification/safety_selftest_launch_control_tb.sv */
`timescale 1ns/10ps
module safety_selftest_launch_control_tb
   import selftest_launch_pkg::*;
;
   logic i_clk = 1'b0, i_rst_n = 1'b0, dev_rst = 1'b0, lock = 1'b0, sched = 1'b0;
   logic afrd = 1'b0, lrd = 1'b0, nclr = 1'b0, lbwr = 1'b0, lbd = 1'b0, lreq = 1'b0;
   logic pin_drv = 1'b0, nvm_q, blk_q, pin_q, to_q;
   reg_write_t     wr_bus = '0;
   analog_report_t arep;
   logic_report_t  lrep;
   device_state_t  state_q;
   logic [7:0]  dly = 8'h06, an_q, lg_q, r;
   logic [3:0]  fail = 4'h0, dn_q, fl_q, cnt_q;
   logic [6:0]  res = 7'h00, rs_q, rv;
   logic [6:0]  map [6] = '{7'h03, 7'h08, 7'h10, 7'h20, 7'h40, 7'h05};
   logic [31:0] seed = 32'h0000_26db;
   int err_count = 0, checked = 0, cycles = 0;
   logic [7:0] exp_an = 8'h00, exp_lg = 8'h00;

   safety_selftest_launch_control #(.TIMEOUT_CYC(60)) dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_dev_reset(dev_rst),
      .i_selftest_ctrl_write_lock(lock), .i_reg_write(wr_bus), .i_analog_report(arep),
      .i_logic_report(lrep), .i_analog_sched_en(sched), .i_analog_flags_rd(afrd),
      .i_logic_result_rd(lrd), .i_nvm_crc_err(1'b0), .i_nvm_fault_clr(nclr),
      .i_leave_block_wr(lbwr), .i_leave_block_data(lbd), .i_diag_leave_request(lreq),
      .i_timeout_flag_rd(1'b0), .i_enable_pin_drive(pin_drv),
      .o_analog_selftest_launch(an_q), .o_logic_selftest_diag_launch(lg_q),
      .o_analog_group_done_flag(dn_q), .o_analog_group_fail_flag(fl_q),
      .o_logic_selftest_result(rs_q), .o_nvm_crc_fault_flag(nvm_q),
      .o_diag_leave_block(blk_q), .o_enable_or_interrupt_pin(pin_q), .o_state(state_q),
      .o_diag_timeout_flag(to_q), .o_device_fault_counter(cnt_q));

   selftest_engine_model engine (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_dly(dly), .i_fail(fail), .i_result(res),
      .i_analog_launch(an_q), .i_logic_launch(lg_q),
      .o_analog_report(arep), .o_logic_report(lrep));

   always #5 i_clk = ~i_clk;

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc

   // lock rides with the write so a locked write is really presented
   task automatic wr(input logic sel, input logic [7:0] d, input logic lk);
      @(posedge i_clk);
      wr_bus <= {1'b1, sel, d};
      lock   <= lk;
      @(posedge i_clk);
      wr_bus.valid <= 1'b0;
      #1;
      if (!lk && sel) exp_lg = d & LOGIC_LAUNCH_MASK;
      if (!lk && !sel) exp_an = d & ANALOG_LAUNCH_MASK;
   endtask : wr

   task automatic pulse(input int k, input logic v);
      @(posedge i_clk);
      lbd <= v;
      case (k)
         0: afrd <= 1'b1;
         1: lrd <= 1'b1;
         2: nclr <= 1'b1;
         3: dev_rst <= 1'b1;
         default: lbwr <= 1'b1;
      endcase
      @(posedge i_clk);
      {afrd, lrd, nclr, dev_rst, lbwr} <= 5'h00;
      #1;
   endtask : pulse

   task automatic wait_clr(input logic sel, input int b);
      int n;
      n = 0;
      while (n < 60 && (sel ? lg_q[b] : an_q[b]) !== 1'b0) begin
         cyc(1);
         n++;
      end
   endtask : wait_clr

   task print_verdict();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   always @(posedge i_clk) begin
      cycles++;
      if (cycles > 3000) begin
         err_count++;
         print_verdict();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      chk("analog launch", 8'h00, an_q);
      chk("logic launch", 8'h00, lg_q);
      cyc(62);
      chk("state", ST_SAFE, state_q);
      chk("timeout flag", 8'h01, to_q);
      chk("fault count", 8'h01, cnt_q);
      $display("test timeout done");
      dly <= 8'hff;
      for (int i = 0; i < 24; i++) begin
         r = xs();
         wr(seed[8], r, seed[9]);
         chk("analog launch", exp_an, an_q);
         chk("logic launch", exp_lg, lg_q);
      end
      wr(1'b0, 8'h0f, 1'b0);
      pulse(3, 1'b0);
      chk("analog launch", 8'h00, an_q);
      chk("state", ST_DIAG, state_q);
      $display("test writes done");
      dly <= 8'h06;
      pulse(4, 1'b1);
      wr(1'b1, 8'h01, 1'b0);
      chk("leave block", 8'h00, blk_q);
      wait_clr(1'b1, 0);
      pulse(4, 1'b1);
      chk("leave block", 8'h01, blk_q);
      @(posedge i_clk);
      lreq <= 1'b1;
      cyc(3);
      chk("state", ST_DIAG, state_q);
      pulse(4, 1'b0);
      cyc(2);
      chk("state", ST_ACTIVE, state_q);
      $display("test diagnostic done");
      pulse(0, 1'b0);
      r = xs();
      fail  <= r[3:0];
      sched <= 1'b1;
      wr(1'b0, 8'h0f, 1'b0);
      cyc(10);
      chk("done flags", 8'h0f, dn_q);
      chk("fail flags", r[3:0], fl_q);
      chk("analog launch", 8'h0f, an_q);
      @(posedge i_clk);
      sched <= 1'b0;
      wait_clr(1'b0, 3);
      chk("analog launch", 8'h00, an_q);
      pulse(0, 1'b0);
      chk("done flags", 8'h00, dn_q);
      $display("test analog done");
      @(posedge i_clk);
      pin_drv <= 1'b1;
      for (int b = 0; b < 6; b++) begin
         pulse(1, 1'b0);
         r  = xs();
         rv = r[6:0] & ((b == 3) ? 7'h5f : 7'h7f);
         res <= rv;
         wr(1'b1, 8'h01 << b, 1'b0);
         if (b == 0) begin
            @(posedge i_clk);
            pin_drv <= 1'b0;
            cyc(2);
            chk("pin frozen", 8'h01, pin_q);
         end
         if (b == 3) begin
            pulse(2, 1'b0);
            chk("nvm fault", 8'h01, nvm_q);
         end
         wait_clr(1'b1, b);
         chk("logic launch", 8'h00, lg_q);
         chk("result", rv & map[b], rs_q);
         if (b == 3) begin
            pulse(2, 1'b0);
            chk("nvm fault", 8'h00, nvm_q);
         end
         if (b == 0) begin
            cyc(2);
            chk("pin released", 8'h00, pin_q);
         end
      end
      $display("test logic done");
      print_verdict();
   end
endmodule : safety_selftest_launch_control_tb

/* File: verification/selftest_engine_model.sv */
`timescale 1ns/10ps
module selftest_engine_model
   import selftest_launch_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_dly,
   input  wire logic [3:0] i_fail,
   input  wire logic [6:0] i_result,
   input  wire logic [7:0] i_analog_launch,
   input  wire logic [7:0] i_logic_launch,
   output analog_report_t  o_analog_report,
   output logic_report_t   o_logic_report
);
   // ****************************************
   // test engine: done after i_dly cycles
   // ****************************************
   logic [7:0] cnt_reg;
   logic       idle;
   logic       hit;
   assign idle = (i_analog_launch | i_logic_launch) == 8'h00;
   assign hit  = (cnt_reg == i_dly) && !idle;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) cnt_reg <= 8'h00;
      else if (hit || idle) cnt_reg <= 8'h00;
      else cnt_reg <= cnt_reg + 8'h01;
   end
   // fail and result carry junk outside the done cycle
   always_comb begin
      o_analog_report.done  = hit ? i_analog_launch[3:0] : 4'h0;
      o_analog_report.fail  = hit ? i_fail : ~i_fail;
      o_logic_report.done   = hit ? i_logic_launch[5:0] : 6'h00;
      o_logic_report.result = hit ? i_result : ~i_result;
   end
endmodule : selftest_engine_model
